// ==== inc/clock_gate_protect_calib_pkg.sv ====
// Constants shared by the peripheral clock, protection and trim registers.
package clock_gate_protect_calib_pkg;

    // Register byte addresses on the register bus.
    localparam logic [31:0] ADDR_PROTECT_MODE  = 32'h400e04e4;
    localparam logic [31:0] ADDR_PROTECT_STAT  = 32'h400e04e8;
    localparam logic [31:0] ADDR_CLK_ENABLE    = 32'h400e0500;
    localparam logic [31:0] ADDR_CLK_DISABLE   = 32'h400e0504;
    localparam logic [31:0] ADDR_CLK_STATE     = 32'h400e0508;
    localparam logic [31:0] ADDR_TRIM_SELECT   = 32'h400e0510;
    localparam logic [31:0] ADDR_IRQ_STATUS    = 32'h400e0520;
    localparam logic [31:0] ADDR_IRQ_CLEAR     = 32'h400e0524;
    localparam logic [31:0] ADDR_IRQ_ENABLE    = 32'h400e0528;

    // Protection mode register layout.
    localparam logic [23:0] PROTECT_KEY        = 24'h504d43;
    localparam int          PROTECT_KEY_LSB    = 8;
    localparam int          PROTECT_ON_BIT     = 0;

    // Protection status register layout.
    localparam int          VIOL_FLAG_BIT      = 0;
    localparam int          VIOL_SRC_LSB       = 8;
    localparam int          VIOL_SRC_W         = 16;

    // Trim select register layout: three 8-bit lanes, value then select.
    localparam int          TRIM_W             = 7;
    localparam int          TRIM_LOW_LSB       = 0;
    localparam int          TRIM_MID_LSB       = 8;
    localparam int          TRIM_HIGH_LSB      = 16;
    localparam int          TRIM_SEL_OFS       = 7;
    localparam int          TRIM_REG_W         = 24;

    // Interrupt event bit positions.
    localparam int          IRQ_EV_W           = 2;
    localparam int          IRQ_VIOLATION_BIT  = 0;
    localparam int          IRQ_KEY_REJECT_BIT = 1;

    // Values after reset.
    localparam logic        PROTECT_ON_RST     = 1'b0;
    localparam logic [23:0] TRIM_REG_RST       = 24'h000000;
    localparam logic [1:0]  IRQ_RST            = 2'h0;

endpackage

// ==== rtl/clock_gate_protect_calib_regs.sv ====
// Upper peripheral clock gates, write protection and RC trim selection.
//
// Behaviour
// - A write-protection violation sets the status flag in bit 0, which stays set until the status register is read.
// - While the flag is set, bits 23 to 8 of the status register hold the low address bits of the refused register.
// - Reading the status register clears both the flag and the source field.
// - Writes to clock enable, clock disable and trim select are ignored while protection is on.
// - A one in bits 0 to 2 of clock enable turns on the clock of peripheral 32 to 34; zeros change nothing.
// - A one in bits 0 to 2 of clock disable turns off the matching peripheral clock; zeros change nothing.
// - The clock state register shows in bits 0 to 2 a one for every enabled peripheral clock.
// - Bits for peripherals that are not implemented have no effect at all.
// - The low trim lane applies the user value in bits 6 to 0 when bit 7 is one, else the flash value.
// - The mid trim lane applies the user value in bits 14 to 8 when bit 15 is one, else the flash value.
// - The high trim lane applies the user value in bits 22 to 16 when bit 23 is one, else the flash value.
// - The protection bit changes only when the upper 24 bits of the write carry the key.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps

module clock_gate_protect_calib_regs #(
    parameter int NUM_PERIPH = 3
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [31:0]           adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    input  wire logic [6:0]            flash_trim_low_i,
    input  wire logic [6:0]            flash_trim_mid_i,
    input  wire logic [6:0]            flash_trim_high_i,
    output logic      [NUM_PERIPH-1:0] periph_clock_bit_o,
    output logic      [6:0]            trim_low_o,
    output logic      [6:0]            trim_mid_o,
    output logic      [6:0]            trim_high_o,
    output logic                       irq_o
);

    // Register map, all compared in the full 32-bit address.
    //   Protection mode      read-write  bit 0 protection on, key in 31:8.
    //   Protection status    read-clear  bit 0 flag, 23:8 source address.
    //   Clock enable         write-only  bits 0 to 2 set the gates.
    //   Clock disable        write-only  bits 0 to 2 clear the gates.
    //   Clock state          read-only   bits 0 to 2 show the gates.
    //   Trim select          read-write  three lanes of value and select.
    //   Interrupt status     read-only   bit 0 violation, bit 1 bad key.
    //   Interrupt clear      write-only  a one clears the status bit.
    //   Interrupt enable     read-write  same layout as the status.
    // Any other address answers as well, reads zero and ignores writes.
    //
    // Bus timing.
    // Every request is answered one cycle after it is taken, so a classic
    // master sees a fixed single wait state and never a retry or error.
    // The ack register also masks the request in its own cycle, which keeps
    // a master that is slow to drop the strobe from being served twice.
    // Read data is registered with the ack and falls back to zero on the
    // next write access, so stale values never linger on the data bus.
    // Writes to the write-only registers read back as zero.
    //
    // Protection.
    // The mode register needs the key in all three upper bytes, so only a
    // full-word write can change the protection bit. A partial write, or a
    // write with any other key, leaves the bit alone and raises the bad key
    // event instead, which lets software notice a stray access.
    // The key itself is never stored and always reads as zero.
    // Only the clock enable, clock disable and trim select registers are
    // guarded here; other guarded registers of the controller live in other
    // blocks, which keep their own violation records.
    // A refused write records the low sixteen address bits as its source.
    // Two refused writes before a read leave the later source in place; the
    // flag cannot count them, so software should read status promptly.
    //
    // Status read and clear.
    // Reading the status register returns the contents from before the read
    // and clears them at the same edge. A violation that arrives on that
    // very edge is kept for the next read instead of being lost, because
    // the set is tested ahead of the clear.
    // With a single bus master the two cannot meet in one cycle today, but
    // the ordering keeps the block safe if a second port is ever added.
    //
    // Clock gates.
    // Set and clear registers avoid a read-modify-write on shared state, so
    // two drivers of different gates cannot undo each other's work.
    // Only the lowest byte lane carries gate bits; a write with that lane
    // off changes nothing. Bits above the implemented gates are dropped.
    // Gates come straight from flip-flops so that downstream clock gating
    // cells see a glitch-free enable.
    //
    // Trims.
    // The trim register is written lane by lane under the byte selects,
    // so software can change one oscillator without touching the others.
    // The applied trims are registered one cycle after the register or the
    // flash value changes; the oscillator cannot react faster anyway.
    // After reset all selects are zero, so the flash values are applied one
    // cycle after reset is released.
    //
    // Interrupts.
    // Each event sets a sticky status bit; a set always beats a clear that
    // falls in the same cycle, so no event is ever dropped.
    // The interrupt line is registered and so follows status and enable one
    // cycle late, which also keeps it free of decode glitches.
    //
    // Clock enable.
    // While the clock enable is low every register holds, the ack included,
    // so a bus request simply waits until the enable returns.
    // The master must not give up a request during such a pause.
    //
    // Reset.
    // The reset is synchronous and must be held for at least one edge; it acts even while
    // the clock enable is low. The first request may follow at once.
    //
    // Limitations.
    // The source field holds an address, not a register code, so software
    // should compare it against the low address bits of the guarded
    // registers.
    // The block has one clock; a bus in another domain needs a bridge.
    // Nothing here protects the interrupt or mode registers themselves.

    // Only peripherals 32 to 34 exist in this bank; wider settings are refused.
    generate
        if (NUM_PERIPH < 1 || NUM_PERIPH > 3) begin : g_bad_param
            $error("NUM_PERIPH must lie between 1 and 3.");
        end
    endgenerate

    // Expands the byte selects into a bit mask for partial writes.
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // Picks the applied trim from one lane of the select register.
    function automatic logic [6:0] pick_trim(input logic [7:0] lane,
                                             input logic [6:0] flash);
        pick_trim = lane[clock_gate_protect_calib_pkg::TRIM_SEL_OFS] ?
                    lane[6:0] : flash;
    endfunction

    logic                  ack_q;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic                  protection_on_q;
    logic                  violation_flag_q;
    logic [15:0]           violation_source_q;
    logic [NUM_PERIPH-1:0] clk_en_q;
    logic [23:0]           trim_reg_q;
    logic [6:0]            trim_low_q;
    logic [6:0]            trim_mid_q;
    logic [6:0]            trim_high_q;
    logic [1:0]            irq_stat_q;
    logic [1:0]            irq_stat_d;
    logic [1:0]            irq_en_q;
    logic                  irq_q;
    logic                  access;
    logic                  wr;
    logic                  rd;
    logic                  hit_mode;
    logic                  hit_stat;
    logic                  hit_en;
    logic                  hit_dis;
    logic                  hit_state;
    logic                  hit_trim;
    logic                  hit_istat;
    logic                  hit_iclr;
    logic                  hit_ien;
    logic                  hit_protected;
    logic                  violation;
    logic                  key_ok;
    logic                  key_reject;
    logic [31:0]           wmask;

    // A request is taken once; the registered ack closes it a cycle later.
    assign access   = cyc_i & stb_i & ~ack_q;
    assign wr       = access & we_i;
    assign rd       = access & ~we_i;
    assign wmask    = lane_mask(sel_i);

    // Address decode.
    assign hit_mode  = adr_i == clock_gate_protect_calib_pkg::ADDR_PROTECT_MODE;
    assign hit_stat  = adr_i == clock_gate_protect_calib_pkg::ADDR_PROTECT_STAT;
    assign hit_en    = adr_i == clock_gate_protect_calib_pkg::ADDR_CLK_ENABLE;
    assign hit_dis   = adr_i == clock_gate_protect_calib_pkg::ADDR_CLK_DISABLE;
    assign hit_state = adr_i == clock_gate_protect_calib_pkg::ADDR_CLK_STATE;
    assign hit_trim  = adr_i == clock_gate_protect_calib_pkg::ADDR_TRIM_SELECT;
    assign hit_istat = adr_i == clock_gate_protect_calib_pkg::ADDR_IRQ_STATUS;
    assign hit_iclr  = adr_i == clock_gate_protect_calib_pkg::ADDR_IRQ_CLEAR;
    assign hit_ien   = adr_i == clock_gate_protect_calib_pkg::ADDR_IRQ_ENABLE;

    // A write to a guarded register while protection is on is a violation.
    assign hit_protected = hit_en | hit_dis | hit_trim;
    assign violation     = wr & protection_on_q & hit_protected;

    // The key must fill the upper three bytes, so all lanes must be written.
    assign key_ok     = (dat_i[31:8] == clock_gate_protect_calib_pkg::PROTECT_KEY)
                        && (sel_i == 4'hf);
    assign key_reject = wr & hit_mode & ~key_ok;

    // Bus handshake; ack is dropped in the cycle after it was given.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= access;
        end
    end

    // Read multiplexer; unmapped and write-only addresses read as zero.
    always_comb begin
        rdata_d = 32'h00000000;
        if (hit_mode) begin
            rdata_d[clock_gate_protect_calib_pkg::PROTECT_ON_BIT] =
                protection_on_q;
        end else if (hit_stat) begin
            rdata_d[clock_gate_protect_calib_pkg::VIOL_FLAG_BIT] =
                violation_flag_q;
            rdata_d[23:8] = violation_source_q;
        end else if (hit_state) begin
            rdata_d[NUM_PERIPH-1:0] = clk_en_q;
        end else if (hit_trim) begin
            rdata_d[23:0] = trim_reg_q;
        end else if (hit_istat) begin
            rdata_d[1:0] = irq_stat_q;
        end else if (hit_ien) begin
            rdata_d[1:0] = irq_en_q;
        end
    end

    // Read data is captured with the ack so it is stable for the master.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h00000000;
        end else if (ce_i) begin
            if (rd) begin
                rdata_q <= rdata_d;
            end else if (access) begin
                rdata_q <= 32'h00000000;
            end
        end
    end

    // Protection bit; a wrong key leaves it untouched.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            protection_on_q <= clock_gate_protect_calib_pkg::PROTECT_ON_RST;
        end else if (ce_i) begin
            if (wr && hit_mode && key_ok) begin
                protection_on_q <=
                    dat_i[clock_gate_protect_calib_pkg::PROTECT_ON_BIT];
            end
        end
    end

    // Violation status. The set is tested first so a violation landing on
    // the clearing read survives; the read returns the older contents.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            violation_flag_q   <= 1'b0;
            violation_source_q <= 16'h0000;
        end else if (ce_i) begin
            if (violation) begin
                violation_flag_q   <= 1'b1;
                violation_source_q <= adr_i[15:0];
            end else if (rd && hit_stat) begin
                violation_flag_q   <= 1'b0;
                violation_source_q <= 16'h0000;
            end
        end
    end

    // One gate per implemented peripheral; bits above them are never read.
    generate
        for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_clk
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    clk_en_q[i] <= 1'b0;
                end else if (ce_i && wr && !protection_on_q && sel_i[0]) begin
                    if (hit_en && dat_i[i]) begin
                        clk_en_q[i] <= 1'b1;
                    end else if (hit_dis && dat_i[i]) begin
                        clk_en_q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Trim select register with byte-lane writes, blocked under protection.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_reg_q <= clock_gate_protect_calib_pkg::TRIM_REG_RST;
        end else if (ce_i) begin
            if (wr && hit_trim && !protection_on_q) begin
                trim_reg_q <= (trim_reg_q & ~wmask[23:0])
                              | (dat_i[23:0] & wmask[23:0]);
            end
        end
    end

    // Applied trims are registered; a flash change reaches them a cycle late.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_low_q  <= 7'h00;
            trim_mid_q  <= 7'h00;
            trim_high_q <= 7'h00;
        end else if (ce_i) begin
            trim_low_q  <= pick_trim(trim_reg_q[7:0], flash_trim_low_i);
            trim_mid_q  <= pick_trim(trim_reg_q[15:8], flash_trim_mid_i);
            trim_high_q <= pick_trim(trim_reg_q[23:16],
                                     flash_trim_high_i);
        end
    end

    // Sticky events; a new event wins over a clear in the same cycle.
    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr && hit_iclr && sel_i[0]) begin
            irq_stat_d = irq_stat_d & ~dat_i[1:0];
        end
        irq_stat_d[clock_gate_protect_calib_pkg::IRQ_VIOLATION_BIT] =
            irq_stat_d[clock_gate_protect_calib_pkg::IRQ_VIOLATION_BIT]
            | violation;
        irq_stat_d[clock_gate_protect_calib_pkg::IRQ_KEY_REJECT_BIT] =
            irq_stat_d[clock_gate_protect_calib_pkg::IRQ_KEY_REJECT_BIT]
            | key_reject;
    end

    // Interrupt status, enable and the level output.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= clock_gate_protect_calib_pkg::IRQ_RST;
            irq_en_q   <= clock_gate_protect_calib_pkg::IRQ_RST;
            irq_q      <= 1'b0;
        end else if (ce_i) begin
            irq_stat_q <= irq_stat_d;
            if (wr && hit_ien && sel_i[0]) begin
                irq_en_q <= dat_i[1:0];
            end
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    assign ack_o              = ack_q;
    assign dat_o              = rdata_q;
    assign periph_clock_bit_o = clk_en_q;
    assign trim_low_o         = trim_low_q;
    assign trim_mid_o         = trim_mid_q;
    assign trim_high_o        = trim_high_q;
    assign irq_o              = irq_q;

endmodule

// ==== bench/clock_gate_protect_calib_properties.sv ====
// Concurrent checks on the register bus, clock gates, protection and trims.
`timescale 1ns/1ps

module clock_gate_protect_calib_checker #(
    parameter int NUM_PERIPH = 3
) (
    input logic                  clk_i,
    input logic                  rst_i,
    input logic                  ce_i,
    input logic                  cyc_i,
    input logic                  stb_i,
    input logic                  we_i,
    input logic [31:0]           adr_i,
    input logic [3:0]            sel_i,
    input logic [31:0]           dat_i,
    input logic [31:0]           dat_o,
    input logic                  ack_o,
    input logic [6:0]            flash_trim_low_i,
    input logic [6:0]            flash_trim_mid_i,
    input logic [6:0]            flash_trim_high_i,
    input logic [NUM_PERIPH-1:0] periph_clock_bit_o,
    input logic [6:0]            trim_low_o,
    input logic [6:0]            trim_mid_o,
    input logic [6:0]            trim_high_o
);
    logic prot_q;
    logic viol_q;
    logic wr;
    logic rd_stat;
    logic wr_prot;
    logic wr_trim;
    logic wr_gate;

    // Decode of requests taken at this edge.
    assign wr = cyc_i && stb_i && we_i && !ack_o && ce_i;
    assign rd_stat = cyc_i && stb_i && !we_i && !ack_o && ce_i
        && adr_i == 32'h400e04e8;
    assign wr_gate = wr && (adr_i == 32'h400e0500 || adr_i == 32'h400e0504);
    assign wr_prot = (wr_gate || wr && adr_i == 32'h400e0510) && prot_q;
    assign wr_trim = wr && adr_i == 32'h400e0510 && sel_i == 4'hf && !prot_q;

    // Shadow of the protection bit, so a refused write can be recognised.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q <= 1'h0;
        end else if (wr && adr_i == 32'h400e04e4 && sel_i == 4'hf
                     && dat_i[31:8] == 24'h504d43) begin
            prot_q <= dat_i[0];
        end
    end

    // Shadow of the sticky violation flag; a new event beats the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            viol_q <= 1'h0;
        end else if (wr_prot) begin
            viol_q <= 1'h1;
        end else if (rd_stat) begin
            viol_q <= 1'h0;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_pulse: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack stayed high");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("request not answered");
    a_clock_on: assert property (
        $rose(periph_clock_bit_o[0]) |-> $past(wr && adr_i == 32'h400e0500
        && dat_i[0])) else $error("clock turned on without cause");
    a_clock_off: assert property (
        $fell(periph_clock_bit_o[0]) |-> $past(rst_i) || $past(wr
        && adr_i == 32'h400e0504 && dat_i[0]))
        else $error("clock turned off without cause");
    a_gate_protect: assert property (
        wr_gate && prot_q |=> $stable(periph_clock_bit_o))
        else $error("protected gate write took effect");
    a_trim_low: assert property (
        wr_trim |-> ##2 trim_low_o == ($past(dat_i[7], 2) ?
        $past(dat_i[6:0], 2) : flash_trim_low_i))
        else $error("low trim wrong");
    a_trim_mid: assert property (
        wr_trim |-> ##2 trim_mid_o == ($past(dat_i[15], 2) ?
        $past(dat_i[14:8], 2) : flash_trim_mid_i))
        else $error("mid trim wrong");
    a_trim_high: assert property (
        wr_trim |-> ##2 trim_high_o == ($past(dat_i[23], 2) ?
        $past(dat_i[22:16], 2) : flash_trim_high_i))
        else $error("high trim wrong");
    a_viol_read: assert property (
        rd_stat |=> dat_o[0] == $past(viol_q))
        else $error("violation flag wrong on read");
endmodule

bind clock_gate_protect_calib_regs clock_gate_protect_calib_checker #(
    .NUM_PERIPH(NUM_PERIPH)) u_checker (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .flash_trim_low_i(flash_trim_low_i), .flash_trim_mid_i(flash_trim_mid_i),
    .flash_trim_high_i(flash_trim_high_i),
    .periph_clock_bit_o(periph_clock_bit_o), .trim_low_o(trim_low_o),
    .trim_mid_o(trim_mid_o), .trim_high_o(trim_high_o));

// ==== bench/tb.sv ====
// Self-checking bench for the clock gate, protection and trim registers.
`timescale 1ns/1ps

module tb;
    typedef struct packed {
        logic        we;
        logic [11:0] off;
        logic [31:0] dat;
        logic [31:0] exp;
    } row_s;

    logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, cyc_i = 1'h0;
    logic stb_i = 1'h0, we_i = 1'h0, ack_o, irq_o;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o;
    logic [6:0]  fl_low = 7'h11, fl_mid = 7'h22, fl_high = 7'h33;
    logic [6:0]  trim_low_o, trim_mid_o, trim_high_o;
    logic [2:0]  periph_clock_bit_o;
    int          miscompares = 0;
    int          total_checks = 0;
    // Ordinary register traffic; a write ignores the expected column.
    row_s rows [20] = '{
        '{1'h0, 12'h508, 32'h0, 32'h0}, '{1'h1, 12'h500, 32'hfffffffa, 32'h0},
        '{1'h0, 12'h508, 32'h0, 32'h2}, '{1'h1, 12'h500, 32'h5, 32'h0},
        '{1'h0, 12'h508, 32'h0, 32'h7}, '{1'h1, 12'h504, 32'h2, 32'h0},
        '{1'h0, 12'h508, 32'h0, 32'h5}, '{1'h1, 12'h510, 32'h8a05, 32'h0},
        '{1'h0, 12'h510, 32'h0, 32'h8a05},
        '{1'h1, 12'h4e4, 32'h504d4301, 32'h0},
        '{1'h1, 12'h500, 32'h2, 32'h0}, '{1'h0, 12'h508, 32'h0, 32'h5},
        '{1'h0, 12'h4e8, 32'h0, 32'h50001}, '{1'h0, 12'h4e8, 32'h0, 32'h0},
        '{1'h1, 12'h4e4, 32'h12345600, 32'h0},
        '{1'h1, 12'h510, 32'hffffff, 32'h0}, '{1'h0, 12'h510, 32'h0, 32'h8a05},
        '{1'h0, 12'h4e8, 32'h0, 32'h51001},
        '{1'h1, 12'h4e4, 32'h504d4300, 32'h0}, '{1'h0, 12'h600, 32'h0, 32'h0}};

    clock_gate_protect_calib_regs #(.NUM_PERIPH(3)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .flash_trim_low_i(fl_low), .flash_trim_mid_i(fl_mid),
        .flash_trim_high_i(fl_high), .periph_clock_bit_o(periph_clock_bit_o),
        .trim_low_o(trim_low_o), .trim_mid_o(trim_mid_o),
        .trim_high_o(trim_high_o), .irq_o(irq_o));

    // 250 MHz system clock.
    always #2 clk_i = ~clk_i;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic bus cycle; the request is held until ack is sampled.
    task automatic op(input logic w, input logic [11:0] o,
                      input logic [31:0] d, input logic [31:0] e);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= {20'h400e0, o};
        dat_i <= d;
        // Only the watchdog may end this wait.
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1);
        if (!w) chk(dat_o, e);
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The whole run takes well under 200 cycles, so this is ample margin.
    initial begin
        repeat (3000) @(posedge clk_i);
        miscompares++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        for (int i = 0; i < 20; i++) begin
            op(rows[i].we, rows[i].off, rows[i].dat, rows[i].exp);
        end
        $display("table test done");
        op(1'h1, 12'h510, 32'hd57f81, 32'h0);
        chk(32'(trim_low_o), 32'h1);
        chk(32'(trim_mid_o), 32'h22);
        chk(32'(trim_high_o), 32'h55);
        fl_mid <= 7'h2c;
        repeat (2) @(posedge clk_i);
        chk(32'(trim_mid_o), 32'h2c);
        $display("trim test done");
        op(1'h1, 12'h524, 32'h3, 32'h0);
        op(1'h1, 12'h4e4, 32'h0, 32'h0);
        chk(32'(irq_o), 32'h0); // Masked event keeps the line low.
        op(1'h1, 12'h528, 32'h1, 32'h0);
        op(1'h1, 12'h4e4, 32'h504d4301, 32'h0);
        op(1'h1, 12'h504, 32'h1, 32'h0);
        chk(32'(irq_o), 32'h1);
        op(1'h0, 12'h520, 32'h0, 32'h3);
        op(1'h1, 12'h524, 32'h1, 32'h0);
        chk(32'(irq_o), 32'h0);
        op(1'h1, 12'h4e4, 32'h504d4300, 32'h0);
        op(1'h1, 12'h504, 32'h1, 32'h0);
        op(1'h0, 12'h508, 32'h0, 32'h4);
        $display("interrupt test done");
        op(1'h1, 12'h500, 32'h3, 32'h0);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk(32'(periph_clock_bit_o), 32'h0);
        chk(32'(trim_low_o), 32'h11);
        op(1'h1, 12'h500, 32'h4, 32'h0);
        op(1'h0, 12'h508, 32'h0, 32'h4);
        $display("reset test done");
        test_done();
    end
endmodule
